// >>> rtdc_pkg.sv
// Constants, field layouts and carrier types for the reference/test DAC block
package rtdc_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [9:0] RTDC_IDX_REFSEL = 10'h00F; // Reference select
  localparam logic [9:0] RTDC_IDX_POSDAC = 10'h010; // Positive test DAC
  localparam logic [9:0] RTDC_IDX_NEGDAC = 10'h011; // Negative test DAC
  localparam logic [9:0] RTDC_IDX_STATUS = 10'h020; // Code check status
  localparam int RTDC_IDX_MSB = 11; // Word index bits of HADDR
  localparam int RTDC_IDX_LSB = 2;

  // ----------------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------------
  localparam int RTDC_REFP_MSB = 5; // Positive reference select
  localparam int RTDC_REFP_LSB = 3;
  localparam int RTDC_REFN_MSB = 2; // Negative reference select
  localparam int RTDC_REFN_LSB = 0;
  localparam int RTDC_CONN_BIT = 7; // Test DAC pin connect
  localparam int RTDC_LVL_MSB = 4;  // Test DAC level code
  localparam int RTDC_LVL_LSB = 0;
  localparam logic [7:0] RTDC_REFSEL_RST = 8'h00;
  localparam logic [7:0] RTDC_DAC_RST = 8'h00;
  localparam logic [7:0] RTDC_REFSEL_WMASK = 8'h3F; // Bits 7:6 reserved
  localparam logic [7:0] RTDC_DAC_WMASK = 8'h9F;    // Bits 6:5 reserved
  localparam logic [31:0] RTDC_RDATA_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Reference select codes and one-hot route positions
  // ----------------------------------------------------------------------
  localparam logic [2:0] RTDC_REF_INTERNAL = 3'h0; // Internal 2.5 V node
  localparam logic [2:0] RTDC_REF_EXT_A = 3'h1;    // Inputs 0 / 1
  localparam logic [2:0] RTDC_REF_EXT_B = 3'h2;    // Inputs 2 / 3
  localparam logic [2:0] RTDC_REF_EXT_C = 3'h3;    // Inputs 4 / 5
  localparam logic [2:0] RTDC_REF_SUPPLY = 3'h4;   // Analog supply rail
  localparam logic [4:0] RTDC_ROUTE_NONE = 5'h00;

  // ----------------------------------------------------------------------
  // Test DAC level: units of 1/128 V above the negative analog supply
  // ----------------------------------------------------------------------
  localparam logic [9:0] RTDC_LVL_MID = 10'h140;  // 2.5 V midpoint
  localparam logic [3:0] RTDC_EXP_POS_MAX = 4'h9; // 4.5 V top code
  localparam logic [3:0] RTDC_EXP_NEG_MAX = 4'h8; // 1.5 V bottom code
  localparam logic [3:0] RTDC_EXP_ZERO = 4'h0;
  localparam logic [9:0] RTDC_LVL_ONE = 10'h001;
  localparam int RTDC_NUM_DAC = 2; // Positive then negative test DAC

  // ----------------------------------------------------------------------
  // Bus constants, data-phase kinds and carrier structs
  // ----------------------------------------------------------------------
  localparam logic [1:0] RTDC_HRESP_OKAY = 2'b00;
  typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ} rtdc_phase_e;

  // Reference routing: bit 0 internal, 1..3 external, 4 supply
  typedef struct packed {
    logic [4:0] pos_onehot;
    logic [4:0] neg_onehot;
  } rtdc_ref_route_s;

  // One test DAC's analog controls
  typedef struct packed {
    logic pin_connect;
    logic [9:0] level;
    logic code_ok;
  } rtdc_dac_s;

endpackage

// >>> rtdc_level_decode.sv
// Test DAC level code to output level decoder
`timescale 1ns/1ns
module rtdc_level_decode
  import rtdc_pkg::*;
(
  // Level code from the control register
  input wire logic [4:0] code,
  // Decoded level and code check
  output logic [9:0] level,
  output logic ok
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic below; // Bit 4 selects outputs below midpoint
  logic [3:0] expo; // Power-of-two step exponent plus one
  logic [3:0] shamt; // Shift for the step
  logic [9:0] step; // Step size from midpoint

  // Binary weighted steps around the midpoint; reserved codes park at 2.5 V
  always_comb begin
    below = code[4];
    expo = code[3:0];
    shamt = (expo == RTDC_EXP_ZERO) ? RTDC_EXP_ZERO : expo - 4'h1;
    step = RTDC_LVL_ONE << shamt;
    if (code == 5'h00) begin
      ok = 1'b1;
    end else if (expo == RTDC_EXP_ZERO) begin
      ok = 1'b0;
    end else if (below) begin
      ok = (expo <= RTDC_EXP_NEG_MAX);
    end else begin
      ok = (expo <= RTDC_EXP_POS_MAX);
    end
    if (!ok || expo == RTDC_EXP_ZERO) begin
      level = RTDC_LVL_MID;
    end else if (below) begin
      level = RTDC_LVL_MID - step;
    end else begin
      level = RTDC_LVL_MID + step;
    end
  end

endmodule // rtdc_level_decode

// >>> rtdc_top.sv
// Reference select and test DAC control registers on an AHB-Lite slave
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module rtdc_top
  import rtdc_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic [1:0] HRESP,
  // Analog front-end controls
  output rtdc_pkg::rtdc_ref_route_s REF_ROUTE,
  output rtdc_pkg::rtdc_dac_s POS_DAC,
  output rtdc_pkg::rtdc_dac_s NEG_DAC
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Word index match for one register
  function automatic logic idx_hit(input logic [9:0] idx,
                                   input logic [9:0] want);
    idx_hit = (idx == want);
  endfunction

  // Reference code to one-hot switch; reserved codes close nothing
  function automatic logic [4:0] ref_onehot(input logic [2:0] code);
    logic [4:0] res;
    res = RTDC_ROUTE_NONE;
    if (code <= RTDC_REF_SUPPLY) begin
      res[code] = 1'b1;
    end
    ref_onehot = res;
  endfunction

  // ----------------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------------
  rtdc_phase_e phase_reg; // Kind of the pending data phase
  logic [9:0] idx_reg; // Word index of the pending data phase
  logic take; // Address phase accepted this edge

  // A transfer is taken on NONSEQ or SEQ with the bus ready
  assign take = HSEL && HREADY && HTRANS[1];

  // Data phase kind follows the accepted address phase
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      phase_reg <= PH_IDLE;
    end else if (HREADY) begin
      if (!take) begin
        phase_reg <= PH_IDLE;
      end else if (HWRITE) begin
        phase_reg <= PH_WRITE;
      end else begin
        phase_reg <= PH_READ;
      end
    end
  end

  // Word index held for the data phase
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      idx_reg <= 10'h000;
    end else if (take) begin
      idx_reg <= HADDR[RTDC_IDX_MSB:RTDC_IDX_LSB];
    end
  end

  // Zero wait states, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = RTDC_HRESP_OKAY;

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic [7:0] ref_reg; // Reference select register
  logic [7:0] dac_reg [RTDC_NUM_DAC]; // Test DAC control registers
  logic wr_now; // Write data phase completes this edge

  // Writes land at the end of the data phase
  assign wr_now = (phase_reg == PH_WRITE) && HREADY;

  // Reference select; reserved bits never stored
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ref_reg <= RTDC_REFSEL_RST;
    end else if (wr_now && idx_hit(idx_reg, RTDC_IDX_REFSEL)) begin
      ref_reg <= HWDATA[7:0] & RTDC_REFSEL_WMASK;
    end
  end

  // ----------------------------------------------------------------------
  // Test DAC registers and decoded outputs
  // ----------------------------------------------------------------------
  rtdc_dac_s dac_q [RTDC_NUM_DAC]; // Registered DAC controls

  for (genvar gi = 0; gi < RTDC_NUM_DAC; gi++) begin : g_dac
    logic [9:0] idx_me; // This DAC's register index
    logic [9:0] lvl; // Decoded level
    logic lvl_ok; // Code is a listed one

    assign idx_me = (gi == 0) ? RTDC_IDX_POSDAC : RTDC_IDX_NEGDAC;

    // Control register; bits 6:5 always zero
    always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        dac_reg[gi] <= RTDC_DAC_RST;
      end else if (wr_now && idx_hit(idx_reg, idx_me)) begin
        dac_reg[gi] <= HWDATA[7:0] & RTDC_DAC_WMASK;
      end
    end

    // Level code to output level
    rtdc_level_decode u_lvl (
      .code(dac_reg[gi][RTDC_LVL_MSB:RTDC_LVL_LSB]),
      .level(lvl),
      .ok(lvl_ok)
    );

    // Registered analog controls
    always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        dac_q[gi].pin_connect <= 1'b0;
        dac_q[gi].level <= RTDC_LVL_MID;
        dac_q[gi].code_ok <= 1'b1;
      end else begin
        dac_q[gi].pin_connect <= dac_reg[gi][RTDC_CONN_BIT];
        dac_q[gi].level <= lvl;
        dac_q[gi].code_ok <= lvl_ok;
      end
    end
  end

  // Positive DAC drives input 6, negative DAC input 7
  assign POS_DAC = dac_q[0];
  assign NEG_DAC = dac_q[1];

  // ----------------------------------------------------------------------
  // Reference routing
  // ----------------------------------------------------------------------
  rtdc_ref_route_s route_reg; // Registered reference switches

  // One-hot switch drive from the select fields
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      route_reg.pos_onehot <= ref_onehot(RTDC_REF_INTERNAL);
      route_reg.neg_onehot <= ref_onehot(RTDC_REF_INTERNAL);
    end else begin
      route_reg.pos_onehot <=
        ref_onehot(ref_reg[RTDC_REFP_MSB:RTDC_REFP_LSB]);
      route_reg.neg_onehot <=
        ref_onehot(ref_reg[RTDC_REFN_MSB:RTDC_REFN_LSB]);
    end
  end

  assign REF_ROUTE = route_reg;

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [3:0] status; // Live code check flags

  // Bit set means the field holds a reserved code
  always_comb begin
    status[0] = (route_reg.pos_onehot == RTDC_ROUTE_NONE);
    status[1] = (route_reg.neg_onehot == RTDC_ROUTE_NONE);
    status[2] = !dac_q[0].code_ok;
    status[3] = !dac_q[1].code_ok;
  end

  // Read mux; unmapped words and upper bits read zero
  always_comb begin
    HRDATA = RTDC_RDATA_ZERO;
    if (phase_reg == PH_READ) begin
      if (idx_hit(idx_reg, RTDC_IDX_REFSEL)) begin
        HRDATA[7:0] = ref_reg;
      end else if (idx_hit(idx_reg, RTDC_IDX_POSDAC)) begin
        HRDATA[7:0] = dac_reg[0];
      end else if (idx_hit(idx_reg, RTDC_IDX_NEGDAC)) begin
        HRDATA[7:0] = dac_reg[1];
      end else if (idx_hit(idx_reg, RTDC_IDX_STATUS)) begin
        HRDATA[3:0] = status;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  // All three registers are zero on the edge after reset
  reset_values_a: assert property (
    @(posedge MCLK) SYS_RST |=> (ref_reg == RTDC_REFSEL_RST)
      && (dac_reg[0] == RTDC_DAC_RST) && (dac_reg[1] == RTDC_DAC_RST))
    else $error("registers not zero after reset");

  // A write to the reference word stores only the unreserved bits
  refsel_write_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    (wr_now && idx_reg == RTDC_IDX_REFSEL)
      |=> ref_reg == ($past(HWDATA[7:0]) & RTDC_REFSEL_WMASK))
    else $error("reference write not stored");

  // Positive internal reference code closes only the internal switch
  refp_internal_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    (ref_reg[RTDC_REFP_MSB:RTDC_REFP_LSB] == RTDC_REF_INTERNAL)
      |=> REF_ROUTE.pos_onehot == 5'h01)
    else $error("positive internal reference not routed");

  // Positive external B code held for two edges closes only switch 2
  refp_route_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    (ref_reg[5:3] == RTDC_REF_EXT_B) ##1 (ref_reg[5:3] == RTDC_REF_EXT_B)
      |-> REF_ROUTE.pos_onehot == 5'h04)
    else $error("positive reference input 2 not routed");

  // Negative reserved codes open all switches and set status bit 1
  refn_route_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    (ref_reg[2:0] > RTDC_REF_SUPPLY) |=> !(|REF_ROUTE.neg_onehot)
      ##0 (status[1] == 1'b1))
    else $error("reserved negative reference not opened");

  // Reads never return set bits outside the fields
  rsvd_read_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    (phase_reg == PH_READ) |-> (HRDATA[31:8] == 24'h00_0000)
      && !(idx_reg == RTDC_IDX_REFSEL && |HRDATA[7:6])
      && !(idx_reg == RTDC_IDX_POSDAC && |HRDATA[6:5])
      && !(idx_reg == RTDC_IDX_NEGDAC && |HRDATA[6:5]))
    else $error("reserved bits read non-zero");

  // Connect bits follow their registers one edge later
  connect_pins_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    1'b1 |=> (POS_DAC.pin_connect == $past(dac_reg[0][7]))
      && (NEG_DAC.pin_connect == $past(dac_reg[1][7])))
    else $error("test DAC pin connect mismatch");

  // Extreme codes give 4.5 V and 1.5 V
  level_ends_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    1'b1 |=> ($past(dac_reg[0][4:0]) != 5'h09 || POS_DAC.level == 10'h240)
      && ($past(dac_reg[1][4:0]) != 5'h18 || NEG_DAC.level == 10'h0C0))
    else $error("test DAC end levels wrong");

  // Smallest step below sits one unit under the midpoint
  level_steps_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    (dac_reg[1][4:0] == 5'h11) |=> NEG_DAC.level == 10'h13F
      && NEG_DAC.code_ok)
    else $error("smallest step below midpoint wrong");

  // Reserved positive level code 0x19 is flagged and parks at midpoint
  level_rsvd_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    (dac_reg[0][4:0] == 5'h19) |=> !POS_DAC.code_ok
      && POS_DAC.level == RTDC_LVL_MID)
    else $error("reserved level code not flagged");

endmodule // rtdc_top

// >>> rtdc_host_model.sv
// Bus-master model of the host controller that programs the block
`timescale 1ns/1ns
module rtdc_host_model (
  // Clock
  input wire logic mclk,
  // Master request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // Slave answer
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [1:0] hresp
);
  import rtdc_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [1:0] last_resp; // Response seen at the end of the last data phase

  // Idle bus before the first transfer
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    last_resp = RTDC_HRESP_OKAY;
  end

  // ----------------------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------------------
  // Wait for a rising edge with ready high; the answer is taken at that
  // edge, before the slave's flip-flops move on
  task automatic wait_ready(output logic [31:0] data);
    logic rdy;
    rdy = 1'b0;
    data = 32'h0000_0000;
    while (rdy !== 1'b1) begin
      @(posedge mclk);
      rdy = hready;
      data = hrdata;
      last_resp = hresp;
    end
  endtask

  // One single word transfer; entered just after a rising edge
  task automatic transfer(input logic wr, input logic [31:0] addr,
                          input logic [31:0] wdata, output logic [31:0] rdata);
    logic [31:0] unused;
    hsel <= 1'b1;
    htrans <= 2'b10; // Non-sequential
    haddr <= addr;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready(unused);
    hsel <= 1'b0;
    htrans <= 2'b00;
    haddr <= ~addr; // Address released, so no stale value lingers
    hwdata <= wr ? wdata : ~hwdata;
    wait_ready(rdata);
    hwdata <= ~hwdata; // Data released
  endtask
endmodule // rtdc_host_model

// >>> rtdc_test.sv
// Self-checking testbench of the reference select and test DAC registers
`timescale 1ns/1ns
module rtdc_test;
  import rtdc_pkg::*;

  // ----------------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------------
  logic mclk;
  logic sys_rst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hready;
  logic [1:0] hresp;
  rtdc_ref_route_s ref_route;
  rtdc_dac_s pos_dac;
  rtdc_dac_s neg_dac;
  int n_mismatch = 0;
  int comparisons = 0;

  rtdc_top dut_u (.MCLK(mclk), .SYS_RST(sys_rst), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .REF_ROUTE(ref_route),
    .POS_DAC(pos_dac), .NEG_DAC(neg_dac));

  rtdc_host_model host_u (.mclk(mclk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hresp(hresp));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Compare and count
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register write with junk in the unused upper lanes
  task automatic wr(input logic [9:0] idx, input logic [7:0] val);
    logic [31:0] junk;
    host_u.transfer(1'b1, {20'h0_0000, idx, 2'b00}, {24'hA5_A5A5, val}, junk);
    check("write okay", 32'(RTDC_HRESP_OKAY), 32'(host_u.last_resp));
  endtask

  // Register read compared with an expected byte
  task automatic rd_check(input string what, input logic [9:0] idx,
                          input logic [7:0] exp);
    logic [31:0] got;
    host_u.transfer(1'b0, {20'h0_0000, idx, 2'b00}, 32'h0000_0000, got);
    check("read okay", 32'(RTDC_HRESP_OKAY), 32'(host_u.last_resp));
    check(what, {24'h00_0000, exp}, got);
  endtask

  // Expected one-hot route of a reference code; reserved opens all
  function automatic logic [4:0] route(input logic [2:0] c);
    return (c <= 3'h4) ? (5'h01 << c) : 5'h00;
  endfunction

  // Expected DAC controls: level in 1/128 V steps, doubling per code
  function automatic rtdc_dac_s dac_exp(input logic conn, input logic [4:0] c);
    logic [3:0] n;
    n = c[3:0];
    dac_exp = '{conn, RTDC_LVL_MID, 1'b1};
    if (!c[4] && n != 4'h0 && n <= 4'h9) begin
      dac_exp.level = RTDC_LVL_MID + (10'h001 << (n - 4'h1));
    end else if (c[4] && n != 4'h0 && n <= 4'h8) begin
      dac_exp.level = RTDC_LVL_MID - (10'h001 << (n - 4'h1));
    end else if (c != 5'h00) begin
      dac_exp.code_ok = 1'b0;
    end
  endfunction

  // Outputs follow one edge after the register; checked mid-cycle
  task automatic check_out(input logic [7:0] rv, input logic [7:0] pv,
                           input logic [7:0] nv);
    @(posedge mclk);
    @(negedge mclk);
    check("pos route", 32'(route(rv[5:3])), 32'(ref_route.pos_onehot));
    check("neg route", 32'(route(rv[2:0])), 32'(ref_route.neg_onehot));
    check("pos dac", 32'(dac_exp(pv[7], pv[4:0])), 32'(pos_dac));
    check("neg dac", 32'(dac_exp(nv[7], nv[4:0])), 32'(neg_dac));
    @(posedge mclk);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Reset for n cycles, then reset values at the registers and outputs
  task automatic test_reset(input int n);
    sys_rst <= 1'b1;
    repeat (n) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd_check("ref reg", RTDC_IDX_REFSEL, 8'h00);
    rd_check("pos reg", RTDC_IDX_POSDAC, 8'h00);
    rd_check("neg reg", RTDC_IDX_NEGDAC, 8'h00);
    check_out(8'h00, 8'h00, 8'h00);
    $display("test_reset done");
  endtask

  // Every reference code on both fields, reserved bits written as zero
  task automatic test_ref_codes();
    logic [7:0] v;
    logic [7:0] st;
    for (int i = 0; i < 8; i++) begin
      v = {2'b00, 3'(i), 3'(7 - i)};
      wr(RTDC_IDX_REFSEL, v);
      rd_check("ref reg", RTDC_IDX_REFSEL, v & 8'h3F);
      check_out(v, 8'h00, 8'h00);
      st = {6'h00, v[2:0] > 3'h4, v[5:3] > 3'h4};
      rd_check("ref flags", RTDC_IDX_STATUS, st);
    end
    $display("test_ref_codes done");
  endtask

  // Every level code on both DACs, connect bits opposite, reserved zero
  task automatic test_dac_codes();
    logic [7:0] p;
    logic [7:0] n;
    logic [7:0] st;
    rtdc_dac_s ep;
    rtdc_dac_s en;
    wr(RTDC_IDX_REFSEL, 8'h00);
    for (int c = 0; c < 32; c++) begin
      p = {c[0], 2'b00, 5'(c)};
      n = {~c[0], 2'b00, 5'(31 - c)};
      wr(RTDC_IDX_POSDAC, p);
      wr(RTDC_IDX_NEGDAC, n);
      rd_check("pos reg", RTDC_IDX_POSDAC, p & 8'h9F);
      rd_check("neg reg", RTDC_IDX_NEGDAC, n & 8'h9F);
      check_out(8'h00, p, n);
      ep = dac_exp(p[7], p[4:0]);
      en = dac_exp(n[7], n[4:0]);
      st = {4'h0, !en.code_ok, !ep.code_ok, 2'b00};
      rd_check("dac flags", RTDC_IDX_STATUS, st);
    end
    $display("test_dac_codes done");
  endtask

  // Unmapped word between registers reads zero and disturbs nothing
  task automatic test_unmapped();
    wr(RTDC_IDX_REFSEL, 8'h1A);
    wr(10'h012, 8'hFF);
    rd_check("unmapped", 10'h012, 8'h00);
    rd_check("ref reg", RTDC_IDX_REFSEL, 8'h1A);
    check_out(8'h1A, 8'h9F, 8'h00);
    $display("test_unmapped done");
  endtask

  // ----------------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Whole run needs under 2000 cycles; cut a hang well past that
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    $display("watchdog expired");
    give_verdict();
  end

  initial begin
    sys_rst = 1'b1;
    test_reset(10);
    test_ref_codes();
    test_dac_codes();
    test_unmapped();
    test_reset(2);
    give_verdict();
  end
endmodule // rtdc_test
